// [srmp_step_rate_motion_profile.sv]
// stepper motion profile generator with apb registers and command watchdog
// ==========================================================
// Notes on behaviour
// (RULE_01) speeds and velocities count microstep pulses per ten thousand seconds
// (RULE_02) max speed setting is clamped to 500,000,000, i.e. 50,000 pulses/s
// (RULE_03) velocity is signed, sign gives direction; speed is a magnitude
// (RULE_04) accel and decel limits are pulses per second per hundred seconds
// (RULE_05) each 10 ms the speed moves at most by the accel or decel limit
// (RULE_06) decel uses the accel limit unless the shared option is cleared
// (RULE_07) changes inside plus/minus starting speed apply at once
// (RULE_08) enabled timeout (default) raises an error and stops the motor
// (RULE_09) host resends a timeout reset about each second or disables it
// (RULE_10) red error indicator lights while an error stops the motor
// (RULE_11) load-adaptive current reduction is off by default, on only if enabled
// (RULE_12) max speed defaults to 200 microstep pulses per second
// (RULE_13) error output is low normally, high while an error stops the motor
// (RULE_14) timeout reset and other periodic commands restart the interval
// (RULE_15) steps issue at speed/10000 per second; direction follows the sign
`timescale 1ns/1ps
`include "srmp_cfg.svh"

module srmp_step_rate_motion_profile
    import srmp_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `SRMP_TIMEOUT_CYC,
    parameter int unsigned INTERVAL_CYC = `SRMP_INTERVAL_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // stepper driver
    output logic step_out,
    output logic dir_out,
    output logic load_adaptive_current_reduction,
    // error indication
    output logic err_out,
    output logic red_led
);

    // ==========================================================
    // bus decode
    srmp_apb_req_t req;
    logic wr_en;
    logic rd_setup;
    logic addr_ok;

    assign req = '{psel, penable, pwrite, paddr, pwdata};
    assign pready = 1'b1;
    assign wr_en = req.psel && req.penable && req.pwrite;
    assign rd_setup = req.psel && !req.penable && !req.pwrite;

    always_comb begin
        unique case (req.paddr)
            `SRMP_OFF_CTRL,
            `SRMP_OFF_TARGET,
            `SRMP_OFF_MAX_SPEED,
            `SRMP_OFF_START_SPEED,
            `SRMP_OFF_MAX_ACCEL,
            `SRMP_OFF_MAX_DECEL,
            `SRMP_OFF_TIMEOUT_RST,
            `SRMP_OFF_STATUS,
            `SRMP_OFF_CUR_VEL: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // unmapped words answer with an error and read as zero
    assign pslverr = req.psel && req.penable && !addr_ok;

    function automatic logic hit(input logic [11:0] off);
        return wr_en && req.paddr == off;
    endfunction : hit

    function automatic logic [31:0] mag(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v); // RULE_03
    endfunction : mag

    // limits a velocity to plus or minus the speed ceiling
    function automatic logic signed [31:0] clamp(
        input logic signed [31:0] v,
        input logic [31:0] lim
    );
        if (v > $signed(lim))
            return $signed(lim);
        if (v < -$signed(lim))
            return -$signed(lim);
        return v;
    endfunction : clamp

    // ==========================================================
    // configuration registers
    logic [31:0] ctrl;
    logic signed [31:0] target;
    logic [31:0] max_speed;
    logic [31:0] start_speed;
    logic [31:0] max_accel;
    logic [31:0] max_decel;

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            ctrl <= `SRMP_CTRL_RESET; // RULE_06 RULE_08 RULE_11
        else if (hit(`SRMP_OFF_CTRL))
            ctrl <= {29'h0, pwdata[2:0]};
    end

    // writes above the top rate are clamped rather than refused
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            max_speed <= `SRMP_MAX_SPEED_RESET; // RULE_12
        else if (hit(`SRMP_OFF_MAX_SPEED))
            max_speed <= (pwdata > `SRMP_SPEED_LIMIT) ?
                `SRMP_SPEED_LIMIT : pwdata; // RULE_02
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            start_speed <= 32'h0;
        else if (hit(`SRMP_OFF_START_SPEED))
            start_speed <= pwdata;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            max_accel <= `SRMP_ACCEL_RESET;
        else if (hit(`SRMP_OFF_MAX_ACCEL))
            max_accel <= pwdata; // RULE_04
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            max_decel <= `SRMP_ACCEL_RESET;
        else if (hit(`SRMP_OFF_MAX_DECEL))
            max_decel <= pwdata; // RULE_04
    end

    assign load_adaptive_current_reduction = ctrl[`SRMP_CTRL_LACR]; // RULE_11

    // ==========================================================
    // target velocity; periodic commands feed the watchdog
    logic activity;

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            target <= 32'sh0;
        else if (hit(`SRMP_OFF_TARGET))
            target <= $signed(pwdata); // RULE_01 RULE_03
    end

    assign activity = hit(`SRMP_OFF_TARGET) ||
        hit(`SRMP_OFF_TIMEOUT_RST); // RULE_14

    // ==========================================================
    // command watchdog and error latch
    logic [31:0] wd_cnt;
    logic tmo_err;
    logic err_clr;

    assign err_clr = hit(`SRMP_OFF_CTRL) && pwdata[`SRMP_CTRL_CLR_ERR];

    // saturates so a long silence cannot wrap back to a fed count
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            wd_cnt <= 32'h0;
        else if (activity || !ctrl[`SRMP_CTRL_TMO_EN])
            wd_cnt <= 32'h0; // RULE_14
        else if (wd_cnt < TIMEOUT_CYC)
            wd_cnt <= wd_cnt + 32'h1;
    end

    // expiry wins over a simultaneous clear so no timeout is lost
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            tmo_err <= 1'b0;
        else if (ctrl[`SRMP_CTRL_TMO_EN] && wd_cnt >= TIMEOUT_CYC - 1)
            tmo_err <= 1'b1; // RULE_08
        else if (err_clr)
            tmo_err <= 1'b0;
    end

    assign err_out = tmo_err; // RULE_13
    assign red_led = tmo_err; // RULE_10

    // ==========================================================
    // 10 ms ramp tick
    // free-running, so a new target waits for the next ramp slot
    logic [31:0] tick_cnt;
    logic tick;

    assign tick = tick_cnt == INTERVAL_CYC - 1;

    always_ff @(posedge ref_clk) begin
        if (!rst_b || tick)
            tick_cnt <= 32'h0;
        else
            tick_cnt <= tick_cnt + 32'h1;
    end

    // ==========================================================
    // velocity ramp
    logic signed [31:0] cur_vel;
    logic signed [31:0] goal;
    logic signed [32:0] diff;
    logic [31:0] dec_lim;
    logic [31:0] step_lim;
    logic speeding_up;
    logic signed [31:0] next_vel;

    always_comb begin
        // an error forces the goal to standstill
        if (tmo_err)
            goal = 32'sh0; // RULE_08
        else
            goal = clamp(target, max_speed);
        diff = 33'(goal) - 33'(cur_vel);
        dec_lim = ctrl[`SRMP_CTRL_SHARED] ? max_accel : max_decel; // RULE_06
        speeding_up = (cur_vel == 0) || (goal[31] == cur_vel[31] &&
            mag(goal) > mag(cur_vel));
        step_lim = speeding_up ? max_accel : dec_lim; // RULE_05
        if (mag(goal) <= start_speed && mag(cur_vel) <= start_speed)
            next_vel = goal; // RULE_07
        else if (diff > $signed({1'b0, step_lim}))
            next_vel = 32'(cur_vel + $signed(step_lim)); // RULE_05
        else if (diff < -$signed({1'b0, step_lim}))
            next_vel = 32'(cur_vel - $signed(step_lim)); // RULE_05
        else
            next_vel = goal;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            cur_vel <= 32'sh0;
        else if (tick)
            cur_vel <= next_vel;
    end

    // ==========================================================
    // motion phase for status, gray coded along stop-accel-cruise-decel
    srmp_motion_t motion;
    srmp_motion_t next_motion;

    always_comb begin
        if (next_vel == 0)
            next_motion = SRMP_MOT_STOP;
        else if (next_vel == goal)
            next_motion = SRMP_MOT_CRUISE;
        else if (speeding_up)
            next_motion = SRMP_MOT_ACCEL;
        else
            next_motion = SRMP_MOT_DECEL;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            motion <= SRMP_MOT_STOP;
        else if (tick)
            motion <= next_motion;
    end

    // ==========================================================
    // step generator: phase accumulator in pulses per 10000 s
    // accumulates speed each cycle; one step per clk_hz*10000 units
    localparam logic [47:0] WRAP = 48'(64'(`SRMP_CLK_HZ) * `SRMP_RATE_UNIT);
    logic [47:0] phase;
    logic [7:0] pulse_cnt;
    logic wrap_hit;
    logic [31:0] spd;

    assign spd = mag(cur_vel);
    assign wrap_hit = (phase + 48'(spd)) >= WRAP;

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            phase <= 48'h0;
        else if (wrap_hit)
            phase <= phase + 48'(spd) - WRAP; // RULE_15
        else
            phase <= phase + 48'(spd);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            pulse_cnt <= 8'h0;
        else if (wrap_hit)
            pulse_cnt <= 8'(`SRMP_PULSE_CYC);
        else if (pulse_cnt != 8'h0)
            pulse_cnt <= pulse_cnt - 8'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            step_out <= 1'b0;
        else
            step_out <= pulse_cnt != 8'h0; // RULE_15
    end

    // holds the last direction through standstill so the driver
    // never sees a spurious reversal
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            dir_out <= 1'b0;
        else if (cur_vel != 0)
            dir_out <= cur_vel[31]; // RULE_03 RULE_15
    end

    // ==========================================================
    // read data
    logic [31:0] rd_word;

    always_comb begin
        unique case (req.paddr)
            `SRMP_OFF_CTRL: rd_word = ctrl;
            `SRMP_OFF_TARGET: rd_word = target;
            `SRMP_OFF_MAX_SPEED: rd_word = max_speed;
            `SRMP_OFF_START_SPEED: rd_word = start_speed;
            `SRMP_OFF_MAX_ACCEL: rd_word = max_accel;
            `SRMP_OFF_MAX_DECEL: rd_word = max_decel;
            `SRMP_OFF_STATUS: rd_word = {28'h0, motion, dir_out, tmo_err};
            `SRMP_OFF_CUR_VEL: rd_word = cur_vel;
            default: rd_word = 32'h0;
        endcase
    end

    // loaded in the setup cycle so the word already stands at the
    // access edge; a value changing in between is seen one cycle old
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            prdata <= 32'h0;
        else if (rd_setup)
            prdata <= rd_word;
    end

endmodule : srmp_step_rate_motion_profile

// [srmp_cfg.svh]
// register offsets, reset values and timing constants for the motion profiler
`ifndef SRMP_CFG_SVH
`define SRMP_CFG_SVH

// ==========================================================
// register byte offsets
`define SRMP_OFF_CTRL 12'h000
`define SRMP_OFF_TARGET 12'h004
`define SRMP_OFF_MAX_SPEED 12'h008
`define SRMP_OFF_START_SPEED 12'h00C
`define SRMP_OFF_MAX_ACCEL 12'h010
`define SRMP_OFF_MAX_DECEL 12'h014
`define SRMP_OFF_TIMEOUT_RST 12'h018
`define SRMP_OFF_STATUS 12'h01C
`define SRMP_OFF_CUR_VEL 12'h020

// ==========================================================
// control bit positions
`define SRMP_CTRL_SHARED 0
`define SRMP_CTRL_TMO_EN 1
`define SRMP_CTRL_LACR 2
`define SRMP_CTRL_CLR_ERR 3

// ==========================================================
// reset values and the max speed limit
`define SRMP_CTRL_RESET 32'h0000_0003
`define SRMP_MAX_SPEED_RESET 32'h001E_8480
`define SRMP_SPEED_LIMIT 32'h1DCD_6500
`define SRMP_ACCEL_RESET 32'h0000_4E20

// ==========================================================
// timing
`define SRMP_CLK_HZ 25000000
`define SRMP_RATE_UNIT 10000
`define SRMP_INTERVAL_MS 10
`define SRMP_INTERVAL_CYC (`SRMP_CLK_HZ / 1000 * `SRMP_INTERVAL_MS)
`define SRMP_TIMEOUT_MS 1000
`define SRMP_TIMEOUT_CYC (`SRMP_CLK_HZ / 1000 * `SRMP_TIMEOUT_MS)
`define SRMP_PULSE_CYC 4

`endif

// [srmp_pkg.sv]
// types shared by the motion profiler
package srmp_pkg;

    // ==========================================================
    // apb request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } srmp_apb_req_t;

    // ==========================================================
    // step output carrier
    typedef struct packed {
        logic step;
        logic dir;
    } srmp_drv_t;

    // ==========================================================
    // motion phase, gray coded along stop, accel, cruise, decel
    typedef enum logic [1:0] {
        SRMP_MOT_STOP = 2'h0,
        SRMP_MOT_ACCEL = 2'h1,
        SRMP_MOT_CRUISE = 2'h3,
        SRMP_MOT_DECEL = 2'h2
    } srmp_motion_t;

endpackage : srmp_pkg

// [srmp_checker.sv]
// port assertions for the motion profiler
`timescale 1ns/1ps
`include "srmp_cfg.svh"
module srmp_checker
    import srmp_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = 200,
    parameter int unsigned INTERVAL_CYC = 20
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // motor side
    input wire logic step_out,
    input wire logic dir_out,
    input wire logic load_adaptive_current_reduction,
    input wire logic err_out,
    input wire logic red_led
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    logic acc;
    logic rd;
    assign acc = psel && penable;
    assign rd = acc && !pwrite;
    // mirror of the timeout enable and the cycles since the last feed
    logic tmo_en_m;
    logic [31:0] idle;
    always_ff @(posedge ref_clk) begin
        if (!rst_b)
            tmo_en_m <= 1'b1;
        else if (acc && pwrite && paddr == `SRMP_OFF_CTRL)
            tmo_en_m <= pwdata[`SRMP_CTRL_TMO_EN];
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !tmo_en_m)
            idle <= 32'h0;
        else if (acc && pwrite && (paddr == `SRMP_OFF_TARGET ||
            paddr == `SRMP_OFF_TIMEOUT_RST))
            idle <= 32'h0;
        else if (idle < TIMEOUT_CYC)
            idle <= idle + 32'h1;
    end
    // ==========================================================
    // properties
    sequence s_pulse;
        step_out [*4] ##1 !step_out;
    endsequence
    property p_pulse;
        $rose(step_out) |-> s_pulse;
    endproperty
    property p_led;
        red_led == err_out;
    endproperty
    property p_hold;
        err_out && !(acc && pwrite && paddr == 12'h000 && pwdata[3])
            |=> err_out;
    endproperty
    property p_lacr;
        acc && pwrite && paddr == 12'h000
            |=> load_adaptive_current_reduction == $past(pwdata[2]);
    endproperty
    property p_clamp;
        rd && paddr == 12'h008 |=> prdata <= `SRMP_SPEED_LIMIT;
    endproperty
    property p_vel;
        rd && paddr == 12'h020
            |=> prdata <= `SRMP_SPEED_LIMIT || -prdata <= `SRMP_SPEED_LIMIT;
    endproperty
    property p_stat;
        psel && !penable && !pwrite && paddr == `SRMP_OFF_STATUS
            |=> prdata[1:0] == {$past(dir_out), $past(err_out)};
    endproperty
    property p_tmo;
        $rose(err_out) |-> idle == TIMEOUT_CYC;
    endproperty
    property p_fire;
        tmo_en_m && idle == TIMEOUT_CYC - 1 |=> err_out;
    endproperty
    property p_ready;
        acc |-> pready;
    endproperty
    property p_slv;
        acc && paddr > 12'h020 |-> pslverr;
    endproperty
    a_pulse: assert property (p_pulse) else $error("step width");
    a_led: assert property (p_led) else $error("led differs");
    a_hold: assert property (p_hold) else $error("error lost");
    a_lacr: assert property (p_lacr) else $error("lacr level");
    a_clamp: assert property (p_clamp) else $error("max speed");
    a_vel: assert property (p_vel) else $error("velocity range");
    a_stat: assert property (p_stat) else $error("status bits");
    a_ready: assert property (p_ready) else $error("pready low");
    a_slv: assert property (p_slv) else $error("no slave error");
    a_tmo: assert property (p_tmo) else $error("early timeout");
    a_fire: assert property (p_fire) else $error("missed timeout");
endmodule : srmp_checker

bind srmp_step_rate_motion_profile srmp_checker #(
    .TIMEOUT_CYC(TIMEOUT_CYC),
    .INTERVAL_CYC(INTERVAL_CYC)
) i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .step_out(step_out),
    .dir_out(dir_out), .err_out(err_out), .red_led(red_led),
    .load_adaptive_current_reduction(load_adaptive_current_reduction));

// [srmp_drv_model.sv]
// stepper driver model counting step pulses
`timescale 1ns/1ps
module srmp_drv_model
    import srmp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // driver inputs
    input wire srmp_drv_t drv,
    // observed steps
    output int steps
);
    logic last;
    // a real driver moves once per rising step edge
    always_ff @(posedge ref_clk) begin
        last <= drv.step;
        if (!rst_b) begin
            steps <= 0;
        end else if (drv.step && !last) begin
            steps <= steps + 1;
        end
    end
endmodule : srmp_drv_model

// [srmp_step_rate_motion_profile_tb.sv]
// self-checking bench for the motion profiler
`timescale 1ns/1ps
`include "srmp_cfg.svh"
module srmp_step_rate_motion_profile_tb import srmp_pkg::*; ;
    localparam int unsigned TMO = 200;
    localparam int unsigned IVL = 20;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] r;
    logic pready, pslverr, step_out, dir_out, lacr, err_out, red_led, err;
    srmp_drv_t drv;
    int steps, n0, failures = 0, compares = 0, cyc = 0;
    assign drv = '{step: step_out, dir: dir_out};
    srmp_step_rate_motion_profile #(.TIMEOUT_CYC(TMO), .INTERVAL_CYC(IVL))
    i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step_out(step_out),
        .dir_out(dir_out), .load_adaptive_current_reduction(lacr),
        .err_out(err_out), .red_led(red_led));
    srmp_drv_model i_drv (.ref_clk(ref_clk), .rst_b(rst_b), .drv(drv),
        .steps(steps));
    always #20 ref_clk = ~ref_clk;
    // ==========================================================
    // bus and reporting
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
        chk("pready", 32'h1, 32'(pready));
        // the answer is taken at the access edge itself
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %0h got %0h", s, e, g);
        end
    endtask : chk
    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wt
    task automatic ramp(input logic [31:0] t, input int lim);
        logic signed [31:0] p, v;
        apb(0, `SRMP_OFF_CUR_VEL, 32'h0);
        p = r;
        v = r;
        apb(1, `SRMP_OFF_TARGET, t);
        for (int k = 0; k < 200 && v !== t; k++) begin
            apb(0, `SRMP_OFF_CUR_VEL, 32'h0);
            v = r;
            chk("ramp step", 1, 32'(v - p <= lim && p - v <= lim));
            p = v;
        end
        chk("ramp end", t, v);
    endtask : ramp
    // ==========================================================
    // scenarios
    task automatic t_regs;
        apb(0, `SRMP_OFF_CTRL, 32'h0);
        chk("ctrl", `SRMP_CTRL_RESET, r);
        apb(0, `SRMP_OFF_MAX_SPEED, 32'h0);
        chk("max_speed", `SRMP_MAX_SPEED_RESET, r);
        chk("lacr off", 0, 32'(lacr));
        apb(1, `SRMP_OFF_CTRL, 32'h0000_0005);
        chk("lacr on", 1, 32'(lacr));
        apb(1, `SRMP_OFF_CTRL, 32'h0000_0001);
        apb(1, `SRMP_OFF_MAX_SPEED, 32'hFFFF_FFFF);
        apb(0, `SRMP_OFF_MAX_SPEED, 32'h0);
        chk("clamp", `SRMP_SPEED_LIMIT, r);
        apb(0, 12'h024, 32'h0);
        chk("unmapped", 0, r);
        chk("slverr", 1, 32'(err));
        $display("test regs done");
    endtask : t_regs
    task automatic t_ramp;
        apb(1, `SRMP_OFF_MAX_ACCEL, 32'h0000_03E8);
        ramp(32'h0000_1388, 1000);
        apb(1, `SRMP_OFF_CTRL, 32'h0000_0000);
        apb(1, `SRMP_OFF_MAX_DECEL, 32'h0000_012C);
        ramp(32'h0000_0000, 300);
        apb(1, `SRMP_OFF_CTRL, 32'h0000_0001);
        apb(1, `SRMP_OFF_START_SPEED, 32'h0000_2710);
        apb(1, `SRMP_OFF_TARGET, 32'h0000_1F40);
        wt(2 * IVL);
        apb(0, `SRMP_OFF_CUR_VEL, 32'h0);
        chk("instant up", 32'h0000_1F40, r);
        apb(1, `SRMP_OFF_TARGET, 32'hFFFF_E0C0);
        wt(2 * IVL);
        apb(0, `SRMP_OFF_CUR_VEL, 32'h0);
        chk("instant rev", 32'hFFFF_E0C0, r);
        apb(0, `SRMP_OFF_STATUS, 32'h0);
        chk("status", 32'hE, r & 32'hF);
        $display("test ramp done");
    endtask : t_ramp
    task automatic t_steps;
        apb(1, `SRMP_OFF_MAX_ACCEL, `SRMP_SPEED_LIMIT);
        apb(1, `SRMP_OFF_TARGET, 32'h0EE6_B280);
        wt(3 * IVL);
        n0 = steps;
        // 25000 steps/s over 400 us gives ten steps
        wt(10000);
        chk("rate", 1, 32'(steps - n0 >= 9 && steps - n0 <= 11));
        chk("dir pos", 0, 32'(dir_out));
        apb(1, `SRMP_OFF_TARGET, 32'hF119_4D80);
        wt(3 * IVL);
        chk("dir neg", 1, 32'(dir_out));
        apb(1, `SRMP_OFF_TARGET, 32'h0);
        wt(3 * IVL);
        $display("test steps done");
    endtask : t_steps
    task automatic t_wdog;
        apb(1, `SRMP_OFF_CTRL, 32'h0000_0003);
        apb(1, `SRMP_OFF_TARGET, 32'h0000_1F40);
        for (int k = 0; k < 5; k++) begin
            wt(TMO / 2);
            apb(1, `SRMP_OFF_TIMEOUT_RST, 32'h0);
        end
        chk("fed", 0, 32'(err_out));
        wt(TMO + 20);
        chk("timeout", 1, 32'(err_out));
        chk("red led", 1, 32'(red_led));
        wt(2 * IVL);
        apb(0, `SRMP_OFF_CUR_VEL, 32'h0);
        chk("stopped", 0, r);
        // timeout off first: a live expiry would win over the clear
        apb(1, `SRMP_OFF_CTRL, 32'h0000_0001);
        apb(1, `SRMP_OFF_CTRL, 32'h0000_0009);
        chk("cleared", 0, 32'(err_out));
        $display("test watchdog done");
    endtask : t_wdog
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            end_sim;
        end
    end
    initial begin
        wt(8);
        rst_b <= 1'b1;
        t_regs;
        t_ramp;
        t_steps;
        t_wdog;
        end_sim;
    end
endmodule : srmp_step_rate_motion_profile_tb
